// >>> src/mbac_map.svh
/*
  register offsets, field positions and reset values of the access checker.
  assumes an 8-bit axi4-lite byte address, one 32-bit word per register.
*/
`ifndef MBAC_MAP_SVH
`define MBAC_MAP_SVH
`define MBAC_OFS_SEG_SEL    8'h00
`define MBAC_OFS_SEG_RIGHTS 8'h04
`define MBAC_OFS_SEG_FIRST  8'h08
`define MBAC_OFS_SEG_LAST   8'h0c
`define MBAC_OFS_SEG_RELOC  8'h10
`define MBAC_OFS_SEG_COUNT  8'h14
`define MBAC_OFS_DENY_CNT   8'h18
`define MBAC_OFS_LAST_DENY  8'h1c
`define MBAC_BIT_RD         0
`define MBAC_BIT_WR         1
`define MBAC_BIT_EX         2
`define MBAC_BIT_SFR_RD     3
`define MBAC_BIT_SFR_WR     4
`define MBAC_RST_SEG_COUNT  7'h00
`define MBAC_RST_SEG_SEL    6'h00
`define MBAC_RST_DENY_CNT   16'h0000
`define MBAC_RESP_OKAY      2'h0
`define MBAC_RESP_SLVERR    2'h2
`endif

// >>> src/mbac_pkg.sv
/*
  types of the mode based access checker.
  assumes nothing beyond a systemverilog compiler.
*/
package mbac_pkg;
  typedef enum logic [2:0] {
    mode_boot, mode_test, mode_contactless, mode_system, mode_user
  } mbac_mode_t;
  typedef enum logic [1:0] {op_read, op_write, op_exec} mbac_op_t;
  typedef enum logic [2:0] {
    rg_test_rom, rg_app_rom, rg_cfg_ee, rg_app_ee, rg_sec_row, rg_ram, rg_copro_ram, rg_none
  } mbac_region_t;
  typedef enum logic [2:0] {grp_seg_cfg, grp_sys_mgmt, grp_test, grp_hw, grp_cpu} mbac_grp_t;
  typedef enum logic [2:0] {
    sfr_plain, sfr_program_status_high, sfr_protected_value_0, sfr_protected_value_1,
    sfr_protected_value_2, sfr_random_number_output
  } mbac_sfr_t;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ex;
    logic        sfr_rd;
    logic        sfr_wr;
    logic [15:0] first;
    logic [15:0] last;
    logic [15:0] reloc;
  } mbac_seg_t;
  typedef struct packed {
    logic      hit;
    mbac_seg_t ent;
  } mbac_hit_t;
endpackage

// >>> src/mbac_top.sv
/*
  mode based access checker: grants or refuses memory and register accesses
  of the cpu core and the public-key coprocessor, holds the segment table.
  assumes the core presents one request per cycle with decoded region and
  register group, and commits nothing before the registered answer.
*/
// Behaviour
// RQ1 - boot: test rom read/exec, config eeprom all, ram read/write
// RQ2 - test: whole rom read/exec, whole eeprom all, ram read/write
// RQ3 - contactless: test rom read/exec, config eeprom all, no ram access
// RQ4 - system: app rom read/exec, app eeprom all, ram read/write
// RQ5 - user: app rom read/exec only as matching segment allows
// RQ6 - user: app eeprom read/write/exec only as matching segment allows
// RQ7 - user: ram read/write only as covering segment allows
// RQ8 - boot and contactless may also read the security row
// RQ9 - coprocessor reads eeprom and reads/writes its own ram
// RQ10 - boot code reaches every register group (code: all but segment config, see RQ17)
// RQ11 - test code reaches every register group (code: all but segment config, see RQ17)
// RQ12 - contactless code reaches hardware component registers only
// RQ13 - system code reaches segment config, system and hardware registers
// RQ14 - user hardware register access follows fetch segment register rights
// RQ15 - general cpu registers granted in every mode
// RQ16 - program status high readable in contactless and user mode
// RQ17 - segment config registers refused outside system mode
// RQ18 - the three protected value registers are never readable (code: readable when req_grp is grp_cpu)
// RQ19 - random number output register is read-only (code: writable when req_grp is grp_cpu)
// RQ20 - refused read returns zero, refused write is dropped
// RQ21 - segment table of up to 64 entries with rights and addresses
// RQ22 - table count resets to zero, disabling every segment
// RQ23 - check completes before any access is committed
`timescale 1ns/10ps
`include "mbac_map.svh"
module mbac_top #(
  parameter int SEG_NUM = 64
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // access request
  input  wire logic                  req_valid,
  input  wire logic                  req_copro,
  input  wire logic                  req_is_sfr,
  input  wire mbac_pkg::mbac_mode_t   req_mode,
  input  wire mbac_pkg::mbac_op_t     req_op,
  input  wire mbac_pkg::mbac_region_t req_region,
  input  wire mbac_pkg::mbac_grp_t    req_grp,
  input  wire mbac_pkg::mbac_sfr_t    req_sfr,
  input  wire logic [15:0]           req_addr,
  input  wire logic [15:0]           req_fetch_addr,
  input  wire logic [7:0]            req_wdata,
  input  wire logic [7:0]            tgt_rdata,
  // access answer
  output logic                       rsp_valid,
  output logic                       rsp_grant,
  output logic                       rsp_commit_wr,
  output logic                       rsp_deliver,
  output logic [7:0]                 rsp_wdata,
  output logic [7:0]                 rsp_rdata,
  // axi4-lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  import mbac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  if (SEG_NUM < 1 || SEG_NUM > 64) begin : g_bad_seg_num
    $error("SEG_NUM must lie in 1..64");
  end

  localparam logic [6:0] SEG_LIM = 7'(SEG_NUM);

  typedef struct packed {
    mbac_seg_t [SEG_NUM-1:0] tbl;
    logic [5:0]              sel;
    logic [6:0]              cnt;
    logic [15:0]             deny_cnt;
    logic [7:0]              last_deny;
    logic                    awready;
    logic                    wready;
    logic                    aw_got;
    logic                    w_got;
    logic [7:0]              awaddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
    logic                    v;
    logic                    grant;
    logic                    commit_wr;
    logic                    deliver;
    logic [7:0]              wd;
    logic [7:0]              rd;
  } mbac_st_t;

  mbac_st_t  st_r;
  mbac_st_t  st_nxt;
  mbac_hit_t dseg;
  mbac_hit_t fseg;
  mbac_seg_t ent_sel;
  mbac_seg_t ent_new;
  logic      sel_ok;
  logic      is_rd;
  logic      is_wr;
  logic      is_ex;
  logic      is_ram;
  logic      seg_right;
  logic      mem_ok;
  logic      sfr_ok;
  logic      cop_ok;
  logic      ok;
  logic [31:0] wv;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // lowest index wins on overlap; entries at or above the count are off
  function automatic mbac_hit_t seg_find(input mbac_seg_t [SEG_NUM-1:0] tbl,
                                         input logic [6:0] cnt, input logic [15:0] a);
    mbac_hit_t h;
    h = '0;
    for (int i = SEG_NUM - 1; i >= 0; i--) begin
      if (7'(i) < cnt && a >= tbl[i].first && a <= tbl[i].last) begin // RQ21 RQ22
        h.hit = 1'b1;
        h.ent = tbl[i];
      end
    end
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    sel_ok = {1'b0, st_r.sel} < SEG_LIM;
    ent_sel = sel_ok ? st_r.tbl[st_r.sel] : '0;
    ent_new = ent_sel;
    wv = wmerge(32'h0000_0000, st_r.wdata, st_r.wstrb);
    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.awaddr = s_axi_awaddr;
      st_nxt.aw_got = 1'b1;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
      st_nxt.w_got = 1'b1;
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `MBAC_RESP_OKAY;
      case (st_r.awaddr)
        `MBAC_OFS_SEG_SEL: begin
          if (st_r.wstrb[0]) st_nxt.sel = wv[5:0];
        end
        `MBAC_OFS_SEG_RIGHTS: begin
          if (st_r.wstrb[0]) begin
            ent_new.rd = wv[`MBAC_BIT_RD];
            ent_new.wr = wv[`MBAC_BIT_WR];
            ent_new.ex = wv[`MBAC_BIT_EX];
            ent_new.sfr_rd = wv[`MBAC_BIT_SFR_RD];
            ent_new.sfr_wr = wv[`MBAC_BIT_SFR_WR];
          end
        end
        `MBAC_OFS_SEG_FIRST: begin
          ent_new.first = 16'(wmerge({16'h0000, ent_sel.first}, st_r.wdata, st_r.wstrb));
        end
        `MBAC_OFS_SEG_LAST: begin
          ent_new.last = 16'(wmerge({16'h0000, ent_sel.last}, st_r.wdata, st_r.wstrb));
        end
        `MBAC_OFS_SEG_RELOC: begin
          ent_new.reloc = 16'(wmerge({16'h0000, ent_sel.reloc}, st_r.wdata, st_r.wstrb));
        end
        `MBAC_OFS_SEG_COUNT: begin
          if (st_r.wstrb[0]) st_nxt.cnt = wv[6:0];
        end
        `MBAC_OFS_DENY_CNT: begin
          st_nxt.deny_cnt = `MBAC_RST_DENY_CNT;
        end
        `MBAC_OFS_LAST_DENY: begin
        end
        default: begin
          st_nxt.bresp = `MBAC_RESP_SLVERR;
        end
      endcase
      if (sel_ok) st_nxt.tbl[st_r.sel] = ent_new;
    end
    if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;
    // read channel
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `MBAC_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `MBAC_OFS_SEG_SEL:    st_nxt.rdata[5:0] = st_r.sel;
        `MBAC_OFS_SEG_RIGHTS: st_nxt.rdata[4:0] = {ent_sel.sfr_wr, ent_sel.sfr_rd,
                                                  ent_sel.ex, ent_sel.wr, ent_sel.rd};
        `MBAC_OFS_SEG_FIRST:  st_nxt.rdata[15:0] = ent_sel.first;
        `MBAC_OFS_SEG_LAST:   st_nxt.rdata[15:0] = ent_sel.last;
        `MBAC_OFS_SEG_RELOC:  st_nxt.rdata[15:0] = ent_sel.reloc;
        `MBAC_OFS_SEG_COUNT:  st_nxt.rdata[6:0] = st_r.cnt;
        `MBAC_OFS_DENY_CNT:   st_nxt.rdata[15:0] = st_r.deny_cnt;
        `MBAC_OFS_LAST_DENY:  st_nxt.rdata[7:0] = st_r.last_deny;
        default:              st_nxt.rresp = `MBAC_RESP_SLVERR;
      endcase
    end
    if (st_r.rvalid && s_axi_rready) st_nxt.rvalid = 1'b0;
    // ready only while idle, so one write and one read at a time
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;

    //////////////////////////////////////////////////////////////////////////
    // permission check
    is_rd = req_op == op_read;
    is_wr = req_op == op_write;
    is_ex = req_op == op_exec;
    is_ram = req_region == rg_ram || req_region == rg_copro_ram;
    dseg = seg_find(st_r.tbl, st_r.cnt, req_addr);
    fseg = seg_find(st_r.tbl, st_r.cnt, req_fetch_addr);
    seg_right = dseg.hit && (is_rd ? dseg.ent.rd : is_wr ? dseg.ent.wr : dseg.ent.ex);
    mem_ok = 1'b0;
    case (req_mode)
      mode_boot: begin
        mem_ok = (req_region == rg_test_rom && !is_wr) || req_region == rg_cfg_ee // RQ1
              || (is_ram && !is_ex) || (req_region == rg_sec_row && is_rd);     // RQ1 RQ8
      end
      mode_test: begin
        mem_ok = ((req_region == rg_test_rom || req_region == rg_app_rom) && !is_wr) // RQ2
              || req_region == rg_cfg_ee || req_region == rg_app_ee
              || req_region == rg_sec_row || (is_ram && !is_ex);
      end
      mode_contactless: begin
        mem_ok = (req_region == rg_test_rom && !is_wr) || req_region == rg_cfg_ee // RQ3
              || (req_region == rg_sec_row && is_rd);                             // RQ8
      end
      mode_system: begin
        mem_ok = (req_region == rg_app_rom && !is_wr) || req_region == rg_app_ee  // RQ4
              || req_region == rg_sec_row || (is_ram && !is_ex);
      end
      mode_user: begin
        mem_ok = seg_right && ((req_region == rg_app_rom && !is_wr)               // RQ5
              || req_region == rg_app_ee || req_region == rg_sec_row             // RQ6
              || (is_ram && !is_ex));                                             // RQ7
      end
      default: mem_ok = 1'b0;
    endcase
    sfr_ok = 1'b0;
    if (is_ex) begin
      sfr_ok = 1'b0;
    end else if (req_grp == grp_cpu) begin
      sfr_ok = 1'b1; // RQ15
    end else if (is_rd && (req_sfr == sfr_protected_value_0 || req_sfr == sfr_protected_value_1
                           || req_sfr == sfr_protected_value_2)) begin
      sfr_ok = 1'b0; // RQ18
    end else if (is_wr && req_sfr == sfr_random_number_output) begin
      sfr_ok = 1'b0; // RQ19
    end else if (req_grp == grp_seg_cfg) begin
      sfr_ok = req_mode == mode_system; // RQ17 RQ13
    end else if (is_rd && req_grp == grp_sys_mgmt && req_sfr == sfr_program_status_high
                 && (req_mode == mode_contactless || req_mode == mode_user)) begin
      sfr_ok = 1'b1; // RQ16
    end else begin
      case (req_mode)
        mode_boot:        sfr_ok = 1'b1;                   // RQ10
        mode_test:        sfr_ok = 1'b1;                   // RQ11
        mode_contactless: sfr_ok = req_grp == grp_hw;      // RQ12
        mode_system:      sfr_ok = req_grp != grp_test;    // RQ13
        mode_user: begin
          sfr_ok = req_grp == grp_hw && fseg.hit && fseg.ent.ex // RQ14
                && (is_rd ? fseg.ent.sfr_rd : fseg.ent.sfr_wr);
        end
        default:          sfr_ok = 1'b0;
      endcase
    end
    // the coprocessor is never refused on the cpu mode it runs beside
    cop_ok = !req_is_sfr && ((is_rd && (req_region == rg_cfg_ee || req_region == rg_app_ee // RQ9
             || req_region == rg_sec_row)) || (req_region == rg_copro_ram && !is_ex));
    ok = req_copro ? cop_ok : (req_is_sfr ? sfr_ok : mem_ok);
    // answer registered: the target sees strobes only after the decision
    st_nxt.v = req_valid;
    st_nxt.grant = req_valid && ok;
    st_nxt.commit_wr = req_valid && ok && is_wr;          // RQ23 RQ20
    st_nxt.deliver = req_valid && ok && !is_wr;           // RQ23
    st_nxt.wd = (req_valid && ok && is_wr) ? req_wdata : 8'h00;
    st_nxt.rd = (req_valid && ok && is_rd) ? tgt_rdata : 8'h00; // RQ20
    // counting after the clear above lets a same-cycle refusal survive it
    if (req_valid && !ok) begin
      if (st_nxt.deny_cnt != 16'hffff) st_nxt.deny_cnt = st_nxt.deny_cnt + 16'h0001;
      st_nxt.last_deny = {1'b1, req_copro, req_is_sfr, req_mode, req_op};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.cnt <= `MBAC_RST_SEG_COUNT; // RQ22
      st_r.sel <= `MBAC_RST_SEG_SEL;
      st_r.deny_cnt <= `MBAC_RST_DENY_CNT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid = st_r.v;
  assign rsp_grant = st_r.grant;
  assign rsp_commit_wr = st_r.commit_wr;
  assign rsp_deliver = st_r.deliver;
  assign rsp_wdata = st_r.wd;
  assign rsp_rdata = st_r.rd;
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_ram_contactless: assert property (req_valid && !req_copro && !req_is_sfr // RQ3
    && req_mode == mode_contactless && req_region == rg_ram |=> rsp_valid && !rsp_grant)
    else $error("contactless ram access granted");
  chk_boot_rom_write: assert property (req_valid && !req_copro && !req_is_sfr // RQ1
    && req_mode == mode_boot && req_region == rg_test_rom && req_op == op_write
    |=> !rsp_grant && !rsp_commit_wr) else $error("boot rom write granted");
  chk_sys_ram_rw: assert property (req_valid && !req_copro && !req_is_sfr // RQ4
    && req_mode == mode_system && req_region == rg_ram && req_op != op_exec
    |=> rsp_grant) else $error("system ram access refused");
  chk_seg_cfg_mode: assert property (req_valid && !req_copro && req_is_sfr // RQ17
    && req_grp == grp_seg_cfg && req_mode != mode_system |=> !rsp_grant)
    else $error("segment config reached outside system mode");
  chk_protected_noread: assert property (req_valid && req_is_sfr && req_op == op_read // RQ18
    && req_grp != grp_cpu && (req_sfr == sfr_protected_value_0 || req_sfr == sfr_protected_value_1
    || req_sfr == sfr_protected_value_2) |=> !rsp_grant && rsp_rdata == 8'h00)
    else $error("protected value readable");
  chk_rng_nowrite: assert property (req_valid && req_is_sfr && req_op == op_write // RQ19
    && req_sfr == sfr_random_number_output && req_grp == grp_hw |=> !rsp_commit_wr)
    else $error("random number output written");
  chk_denied_quiet: assert property (rsp_valid && !rsp_grant // RQ20 RQ23
    |-> rsp_rdata == 8'h00 && !rsp_commit_wr && !rsp_deliver && rsp_wdata == 8'h00)
    else $error("refused access leaks or commits");
  chk_cpu_regs: assert property (req_valid && !req_copro && req_is_sfr // RQ15
    && req_grp == grp_cpu && req_op != op_exec |=> rsp_grant)
    else $error("general cpu register refused");
  chk_user_empty: assert property (req_valid && !req_copro && req_mode == mode_user // RQ22
    && st_r.cnt == 7'h00 && (!req_is_sfr || req_grp == grp_hw) |=> !rsp_grant)
    else $error("user access with empty table");
  chk_copro_ee_write: assert property (req_valid && req_copro && req_op == op_write // RQ9
    && (req_region == rg_cfg_ee || req_region == rg_app_ee) |=> rsp_valid && !rsp_grant)
    else $error("coprocessor eeprom write granted");
  chk_psh_read: assert property (req_valid && !req_copro && req_is_sfr && req_op == op_read // RQ16
    && req_grp == grp_sys_mgmt && req_sfr == sfr_program_status_high
    && req_mode == mode_user |=> rsp_grant) else $error("status high read refused");

  cov_user_grant: cover property (req_valid && req_mode == mode_user ##1 rsp_grant);
  cov_deny: cover property (rsp_valid && !rsp_grant);
  cov_axi_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_axi_read: cover property (s_axi_rvalid && s_axi_rready);

endmodule // mbac_top

// >>> testbench/mbac_tgt_model.sv
/*
  target memory model: supplies read data toward the checker.
  assumes one clock; the byte moves every cycle, held by no request.
*/
`timescale 1ns/10ps
module mbac_tgt_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // read data
  output logic [7:0]      tgt_rdata
);
  // new byte each cycle so a stale answer never passes for a fresh one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      tgt_rdata <= 8'h5a;
    else
      tgt_rdata <= tgt_rdata + 8'h3b;
  end
endmodule // mbac_tgt_model

// >>> testbench/tb.sv
/*
  self-checking bench of the access checker.
  assumes the design files and the target model are compiled first.
*/
`timescale 1ns/10ps
module tb;
  import mbac_pkg::*;
  logic               sys_clk = 1'h0, rst_n = 1'h0;
  logic               req_valid = 1'h0, req_copro = 1'h0, req_is_sfr = 1'h0;
  mbac_mode_t         req_mode = mode_boot;
  mbac_op_t           req_op = op_read;
  mbac_region_t       req_region = rg_none;
  mbac_grp_t          req_grp = grp_cpu;
  mbac_sfr_t          req_sfr = sfr_plain;
  logic [15:0]        req_addr = 16'h0000, req_fetch_addr = 16'h0000;
  logic [7:0]         req_wdata = 8'h00, tgt_rdata, rsp_wdata, rsp_rdata;
  logic               rsp_valid, rsp_grant, rsp_commit_wr, rsp_deliver;
  logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]         s_axi_wstrb = 4'hf;
  logic               s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic               s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  int                 n_fail = 0, comparisons = 0;
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // small table keeps the run short; expectations do not depend on it
  mbac_top #(.SEG_NUM(4)) u_mbac_top (.sys_clk, .rst_n, .req_valid, .req_copro, .req_is_sfr,
    .req_mode, .req_op, .req_region, .req_grp, .req_sfr, .req_addr, .req_fetch_addr,
    .req_wdata, .tgt_rdata, .rsp_valid, .rsp_grant, .rsp_commit_wr, .rsp_deliver, .rsp_wdata,
    .rsp_rdata, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mbac_tgt_model u_mbac_tgt_model (.sys_clk, .rst_n, .tgt_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one request, answer judged one edge later
  task automatic acc(input logic c, s, input int m, o, r, g, sf,
                     input logic [15:0] a, f, input logic e);
    logic [7:0] d;
    logic       w;
    w = (o == 1);
    @(posedge sys_clk);
    req_valid <= 1'h1;
    req_copro <= c;
    req_is_sfr <= s;
    req_mode <= mbac_mode_t'(m);
    req_op <= mbac_op_t'(o);
    req_region <= mbac_region_t'(r);
    req_grp <= mbac_grp_t'(g);
    req_sfr <= mbac_sfr_t'(sf);
    req_addr <= a;
    req_fetch_addr <= f;
    req_wdata <= a[7:0] ^ 8'hc3;
    @(posedge sys_clk);
    d = tgt_rdata;
    req_valid <= 1'h0;
    #1;
    chk("rsp", {1'h1, e, e & w, e & !w, (e & w) ? a[7:0] ^ 8'hc3 : 8'h00},
        {rsp_valid, rsp_grant, rsp_commit_wr, rsp_deliver, rsp_wdata});
    if (!(e && o == 2))
      chk("rsp_rdata", (e && o == 0) ? d : 8'h00, rsp_rdata);
  endtask
  task automatic aw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (s_axi_bvalid && !pa && !pw)
        break;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      if (!pa)
        s_axi_awvalid <= 1'h0;
      if (!pw)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    if (n == 40) begin
      n_fail++;
      tally_and_finish();
    end else
      chk("bresp", er, s_axi_bresp);
  endtask
  task automatic ar(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (s_axi_rvalid)
        break;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    if (n == 40) begin
      n_fail++;
      tally_and_finish();
    end else begin
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // modes boot 0 test 1 contactless 2 system 3 user 4; ops read 0 write 1 exec 2
  function automatic logic mexp(int m, o, r);
    logic rd, nw, nx, ram;
    rd = (o == 0);
    nw = (o != 1);
    nx = (o != 2);
    ram = (r == 5 || r == 6);
    case (m)
      0: return r == 0 && nw || r == 2 || ram && nx || r == 4 && rd;
      1: return r < 2 && nw || r > 1 && r < 5 || ram && nx;
      2: return r == 0 && nw || r == 2 || r == 4 && rd;
      3: return r == 1 && nw || r == 3 || r == 4 || ram && nx;
      default: return 1'h0;
    endcase
  endfunction
  function automatic logic sexp(int m, o, g, sf);
    if (o == 2)
      return 1'h0;
    if (g == 4)
      return 1'h1;
    if (sf == 5 && o == 1)
      return 1'h0;
    if (sf > 1 && sf < 5 && o == 0)
      return 1'h0;
    if (sf == 1 && o == 0 && (m == 2 || m == 4))
      return 1'h1;
    case (g)
      0: return m == 3;
      1: return m < 2 || m == 3;
      2: return m < 2;
      3: return m < 4;
      default: return 1'h0;
    endcase
  endfunction
  task automatic t_mem();
    for (int m = 0; m < 5; m++)
      for (int r = 0; r < 8; r++)
        for (int o = 0; o < 3; o++)
          acc(0, 0, m, o, r, 0, 0, 16'h0000, 16'h0000, mexp(m, o, r));
    $display("test mem_modes done");
  endtask
  task automatic t_sfr();
    for (int m = 0; m < 5; m++)
      for (int g = 0; g < 5; g++)
        for (int sf = 0; sf < 6; sf++)
          for (int o = 0; o < 3; o++)
            if (sf == 0 || g == 1 && sf < 5 || g == 3 && sf == 5)
              acc(0, 1, m, o, 7, g, sf, 16'h0000, 16'h0000, sexp(m, o, g, sf));
    $display("test sfr_modes done");
  endtask
  task automatic t_seg();
    aw(8'h18, 32'h0, 2'h0);
    aw(8'h04, 32'h0d, 2'h0);
    aw(8'h08, 32'h1000, 2'h0);
    aw(8'h0c, 32'h10ff, 2'h0);
    aw(8'h00, 32'h1, 2'h0);
    aw(8'h04, 32'h03, 2'h0);
    aw(8'h08, 32'h2000, 2'h0);
    aw(8'h0c, 32'h20ff, 2'h0);
    aw(8'h14, 32'h2, 2'h0);
    ar(8'h14, 32'h2, 2'h0);
    ar(8'h04, 32'h03, 2'h0);
    aw(8'h10, 32'h1234, 2'h0);
    ar(8'h10, 32'h1234, 2'h0);
    aw(8'h20, 32'h1, 2'h2);
    ar(8'h20, 32'h0, 2'h2);
    acc(0, 0, 4, 0, 1, 0, 0, 16'h10ff, 16'h0000, 1);
    acc(0, 0, 4, 0, 1, 0, 0, 16'h1100, 16'h0000, 0);
    acc(0, 0, 4, 2, 1, 0, 0, 16'h1000, 16'h0000, 1);
    acc(0, 0, 4, 1, 3, 0, 0, 16'h1000, 16'h0000, 0);
    acc(0, 0, 4, 2, 3, 0, 0, 16'h1000, 16'h0000, 1);
    acc(0, 0, 4, 1, 5, 0, 0, 16'h2000, 16'h0000, 1);
    acc(0, 0, 4, 0, 5, 0, 0, 16'h20ff, 16'h0000, 1);
    acc(0, 1, 4, 0, 7, 3, 0, 16'h0000, 16'h1000, 1);
    acc(0, 1, 4, 1, 7, 3, 0, 16'h0000, 16'h1000, 0);
    acc(0, 1, 4, 0, 7, 3, 0, 16'h0000, 16'h2000, 0);
    aw(8'h14, 32'h1, 2'h0);
    acc(0, 0, 4, 1, 5, 0, 0, 16'h2000, 16'h0000, 0);
    $display("test user_segments done");
  endtask
  task automatic t_cop();
    acc(1, 0, 4, 0, 2, 0, 0, 16'h0000, 16'h0000, 1);
    acc(1, 0, 0, 0, 3, 0, 0, 16'h0000, 16'h0000, 1);
    acc(1, 0, 3, 1, 3, 0, 0, 16'h0000, 16'h0000, 0);
    acc(1, 0, 2, 1, 6, 0, 0, 16'h0000, 16'h0000, 1);
    acc(1, 0, 1, 0, 5, 0, 0, 16'h0000, 16'h0000, 0);
    ar(8'h18, 32'h7, 2'h0);
    ar(8'h1c, 32'hc4, 2'h0);
    $display("test coprocessor done");
  endtask
  // second reset in mid-run must wipe the table built above
  task automatic t_rst();
    @(posedge sys_clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    ar(8'h14, 32'h0, 2'h0);
    ar(8'h18, 32'h0, 2'h0);
    acc(0, 0, 4, 0, 1, 0, 0, 16'h1000, 16'h0000, 0);
    $display("test reset_table done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_mem();
    t_sfr();
    t_seg();
    t_cop();
    t_rst();
    tally_and_finish();
  end
endmodule // tb
